// ### hdl/rbe_pkg.sv
// Constants for the receive byte event flag block.
// Assumes an 8-bit register port with 6-bit addresses driven by the SPI slave.
`default_nettype none

package rbe_pkg;
    // Register addresses
    localparam logic [5:0] ADDR_SERDES_CTL = 6'h06;
    localparam logic [5:0] ADDR_RX_EN      = 6'h07;
    localparam logic [5:0] ADDR_RX_STATUS  = 6'h08;
    localparam logic [5:0] ADDR_DATA_A     = 6'h09;
    localparam logic [5:0] ADDR_DATA_B     = 6'h0B;
    // Reset values
    localparam logic [7:0] RST_STATUS      = 8'h00;
    localparam logic [7:0] RST_ENABLE      = 8'h00;
    localparam logic [3:0] RST_SERDES_CTL  = 4'h3;
    // Per-channel nibble layout of status and enable
    localparam int         CH_W            = 4;
    localparam int         ST_LOADED       = 0;
    localparam int         ST_EOF          = 1;
    localparam int         ST_FLOW         = 2;
    localparam int         ST_VALID        = 3;
    localparam int         EN_FULL         = 0;
    localparam int         EN_EOF          = 1;
    localparam int         EN_OVF          = 2;
    localparam int         EN_UNF          = 3;
    // Gap limit field of the serializer control register
    localparam int         GAP_MSB         = 2;
    localparam int         GAP_LSB         = 0;
    localparam logic [2:0] LAST_BIT        = 3'h7;
endpackage : rbe_pkg

`default_nettype wire

// ### hdl/rbe_rx_event_flags.sv
// Receive-side byte assembly, holding registers, event status and interrupt.
// Assumes bit strobes and the register port are on clk_i; reads are one-cycle strobes.
`default_nettype none

// Functional notes
// - Reading channel A data while it holds no unread byte flags an underflow.
// - Loading channel A data while the previous byte is unread flags an overflow.
// - Enable bit 3 gates the A underflow interrupt and bit 2 the A overflow interrupt.
// - Enable bit 1 gates the A end-of-frame interrupt and bit 0 the A loaded interrupt.
// - End of frame needs a valid bit first and fires when invalid bit times exceed the limit.
// - A gap limit of zero gives end of frame at the first invalid bit time.
// - End of frame stays pending until the host reads the status register, which clears it, or receive mode is left.
// - Every transfer into the channel A holding register flags loaded for A.
// - Every transfer into the channel B holding register flags loaded for B.
// - A transfer happens after eight bits, or at end of frame when a partial byte is pending.
// - Status resets to zero; bits 7:4 are B valid, flow, eof, loaded and 3:0 the same for A.
// - The gap limit is bits 2:0 of the serializer control register, in bit times.
// - Flow violation is set by overflow or underflow and cleared by a status read.
// - Valid is set on a transfer of a fully valid byte and never raises the interrupt.
// - Status sets regardless of enables and reads zero outside receive mode.
module rbe_rx_event_flags
    import rbe_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // Receive mode
    input  wire logic       rx_en_i,
    // Per-channel bit stream, index 0 is A
    input  wire logic [1:0] bit_tick_i,
    input  wire logic [1:0] bit_data_i,
    input  wire logic [1:0] bit_ok_i,
    // Register port
    input  wire logic [5:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // Interrupt
    output logic            irq_o
);
    logic [1:0][7:0] shreg, next_shreg, hold, next_hold, load_val;
    logic [1:0][2:0] cnt, next_cnt, gap, next_gap;
    logic [1:0]      seen, next_seen, full, next_full;
    logic [1:0]      rd_data, eof_ev, byte_done, load, ovf, unf;
    logic [1:0]      ovf_st, next_ovf_st, unf_st, next_unf_st;
    logic [7:0]      status, next_status, enable, next_enable, set_vec, next_rdata;
    logic [3:0]      ctl, next_ctl;
    logic [2:0]      gap_lim;
    logic [7:0]      irq_terms;
    logic            stat_rd;

    assign gap_lim = ctl[GAP_MSB:GAP_LSB];
    assign stat_rd = reg_rd_i && (reg_addr_i == ADDR_RX_STATUS);
    assign rd_data[0] = reg_rd_i && (reg_addr_i == ADDR_DATA_A);
    assign rd_data[1] = reg_rd_i && (reg_addr_i == ADDR_DATA_B);

    for (genvar c = 0; c < 2; c++) begin : g_ch
        assign eof_ev[c] = bit_tick_i[c] && !bit_ok_i[c] && seen[c] && (gap[c] >= gap_lim);
        assign byte_done[c] = bit_tick_i[c] && bit_ok_i[c] && (cnt[c] == LAST_BIT);
        assign load[c] = byte_done[c] || (eof_ev[c] && (cnt[c] != 3'h0));
        assign load_val[c] = byte_done[c] ? {bit_data_i[c], shreg[c][6:0]} : shreg[c];
        assign ovf[c] = load[c] && full[c] && !rd_data[c];
        assign unf[c] = rd_data[c] && !full[c];
        assign set_vec[CH_W*c+ST_LOADED] = load[c];
        assign set_vec[CH_W*c+ST_EOF]    = eof_ev[c];
        assign set_vec[CH_W*c+ST_FLOW]   = ovf[c] || unf[c];
        assign set_vec[CH_W*c+ST_VALID]  = byte_done[c];
        assign irq_terms[CH_W*c+EN_FULL] = status[CH_W*c+ST_LOADED] && enable[CH_W*c+EN_FULL];
        assign irq_terms[CH_W*c+EN_EOF]  = status[CH_W*c+ST_EOF] && enable[CH_W*c+EN_EOF];
        assign irq_terms[CH_W*c+EN_OVF]  = ovf_st[c] && enable[CH_W*c+EN_OVF];
        assign irq_terms[CH_W*c+EN_UNF]  = unf_st[c] && enable[CH_W*c+EN_UNF];

        always_comb begin
            next_shreg[c] = shreg[c];
            next_cnt[c]   = cnt[c];
            next_gap[c]   = gap[c];
            next_seen[c]  = seen[c];
            next_hold[c]  = load[c] ? load_val[c] : hold[c];
            next_full[c]  = load[c] || (full[c] && !rd_data[c]);
            if (bit_tick_i[c] && bit_ok_i[c]) begin
                next_shreg[c][cnt[c]] = bit_data_i[c];
                next_cnt[c]  = cnt[c] + 3'h1;
                next_seen[c] = 1'b1;
                next_gap[c]  = 3'h0;
            end else if (eof_ev[c]) begin
                next_cnt[c]  = 3'h0;
                next_seen[c] = 1'b0;
                next_gap[c]  = 3'h0;
            end else if (bit_tick_i[c] && seen[c]) begin
                next_gap[c] = gap[c] + 3'h1;
            end
            if (byte_done[c] || eof_ev[c]) begin
                next_shreg[c] = 8'h00;
            end
            // Leaving receive mode drops any partial frame
            if (!rx_en_i) begin
                next_shreg[c] = 8'h00;
                next_cnt[c]   = 3'h0;
                next_gap[c]   = 3'h0;
                next_seen[c]  = 1'b0;
                next_full[c]  = 1'b0;
            end
        end
    end

    always_comb begin
        next_status = rx_en_i ? ((status & ~{8{stat_rd}}) | set_vec) : RST_STATUS;
        next_ovf_st = rx_en_i ? ((ovf_st & ~{2{stat_rd}}) | ovf) : 2'h0;
        next_unf_st = rx_en_i ? ((unf_st & ~{2{stat_rd}}) | unf) : 2'h0;
        next_enable = (reg_wr_i && reg_addr_i == ADDR_RX_EN) ? reg_wdata_i : enable;
        next_ctl    = (reg_wr_i && reg_addr_i == ADDR_SERDES_CTL) ? reg_wdata_i[3:0] : ctl;
        case (reg_addr_i)
            ADDR_SERDES_CTL: next_rdata = {4'h0, ctl};
            ADDR_RX_EN:      next_rdata = enable;
            ADDR_RX_STATUS:  next_rdata = status;
            ADDR_DATA_A:     next_rdata = hold[0];
            ADDR_DATA_B:     next_rdata = hold[1];
            default:         next_rdata = 8'h00;
        endcase
        if (!reg_rd_i) begin
            next_rdata = reg_rdata_o;
        end
    end

    // valid bits never reach the output
    assign irq_o = |irq_terms;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            shreg       <= '0;
            cnt         <= '0;
            gap         <= '0;
            seen        <= '0;
            hold        <= '0;
            full        <= '0;
            status      <= RST_STATUS;
            ovf_st      <= '0;
            unf_st      <= '0;
            enable      <= RST_ENABLE;
            ctl         <= RST_SERDES_CTL;
            reg_rdata_o <= 8'h00;
        end else begin
            shreg       <= next_shreg;
            cnt         <= next_cnt;
            gap         <= next_gap;
            seen        <= next_seen;
            hold        <= next_hold;
            full        <= next_full;
            status      <= next_status;
            ovf_st      <= next_ovf_st;
            unf_st      <= next_unf_st;
            enable      <= next_enable;
            ctl         <= next_ctl;
            reg_rdata_o <= next_rdata;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    underflow_flag_a: assert property
        (rx_en_i && rd_data[0] && !full[0] |=> status[2] && unf_st[0])
        else $error("underflow on A not flagged");
    data_read_a: assert property
        (rx_en_i && rd_data[0] && !load[0] |=> !full[0])
        else $error("read of A did not empty it");
    overflow_flag_a: assert property
        (rx_en_i && load[0] && full[0] && !rd_data[0] |=> status[2] && ovf_st[0])
        else $error("overflow on A not flagged");
    unf_gate_a: assert property
        (unf_st[0] && !ovf_st[0] && !enable[3] && status[1:0] == 2'h0
        && status[7:4] == 4'h0 |-> !irq_o)
        else $error("underflow interrupt not gated");
    eof_gate_a: assert property
        (status[1] && enable[1] |-> irq_o)
        else $error("eof interrupt not raised");
    eof_after_bit_a: assert property
        (rx_en_i && !seen[0] && !status[1] |=> !status[1])
        else $error("eof without a valid bit");
    eof_zero_a: assert property
        (rx_en_i && gap_lim == 3'h0 && seen[0] && bit_tick_i[0] && !bit_ok_i[0] |=> status[1])
        else $error("eof missed with zero gap");
    eof_hold_a: assert property
        (status[1] && rx_en_i && !stat_rd |=> status[1])
        else $error("eof dropped without status read");
    load_flag_a: assert property
        (rx_en_i && load[0] |=> status[0] && full[0])
        else $error("loaded A not flagged");
    load_b_flag_a: assert property
        (rx_en_i && load[1] |=> status[4] && full[1])
        else $error("loaded B not flagged");
    partial_load_a: assert property
        (rx_en_i && eof_ev[0] && cnt[0] != 3'h0 |=> full[0] && status[0] && !hold[0][7])
        else $error("partial byte not loaded");
    stat_clear_a: assert property
        (stat_rd && set_vec == 8'h00 |=> status == 8'h00)
        else $error("status read did not clear");
    valid_quiet_a: assert property
        ((status & 8'h77) == 8'h00 |-> !irq_o)
        else $error("valid bit raised the interrupt");
    rx_off_a: assert property
        (!rx_en_i |=> status == 8'h00)
        else $error("status not zero outside receive");

    cover_partial: cover property (eof_ev[0] && load[0] && !byte_done[0]);
    cover_overflow: cover property (ovf[1]);
    cover_irq_clear: cover property (irq_o && stat_rd ##1 !irq_o);
    cover_unf_gated: cover property (unf_st[0] && !enable[3] && !irq_o);
    cover_eof_zero: cover property (eof_ev[0] && gap_lim == 3'h0);
endmodule : rbe_rx_event_flags

`default_nettype wire

// ### tb/rbe_host_model.sv
// Host side model: byte reads and writes on the register port.
// Assumes the device samples strobes on the rising edge of clk_i.
`default_nettype none
module rbe_host_model (
    // Clock
    input  wire logic       clk_i,
    // Register port
    output var  logic [5:0] addr_o,
    output var  logic       wr_o,
    output var  logic       rd_o,
    output var  logic [7:0] wdata_o,
    input  wire logic [7:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr_o  = 6'h3F;
        wr_o    = 1'h0;
        rd_o    = 1'h0;
        wdata_o = 8'h00;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'h1;
        @(posedge clk_i);
        wr_o    <= 1'h0;
        // Released data flips so a stale byte is never reused
        wdata_o <= ~d;
        #1;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'h1;
        @(posedge clk_i);
        rd_o   <= 1'h0;
        #1;
        d = rdata_i;
    endtask : rd
endmodule : rbe_host_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the receive byte event flags.
// Assumes rbe_host_model drives the register port; bits are driven here.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rbe_pkg::*;
    logic       clk = 1'h0;
    logic       srst = 1'h1;
    logic       rx_en = 1'h1;
    logic [1:0] tick = 2'h0;
    logic [1:0] bdat = 2'h0;
    logic [1:0] bok = 2'h0;
    logic [5:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] b;
    logic [7:0] v;
    logic       irq;
    int         n_fail = 0;
    int         checks_done = 0;
    int         seed = 32'h35eb76c0;
    always #5 clk = ~clk;
    rbe_rx_event_flags dut (.clk_i(clk), .srst_i(srst), .rx_en_i(rx_en), .bit_tick_i(tick),
        .bit_data_i(bdat), .bit_ok_i(bok), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .irq_o(irq));
    rbe_host_model host (.clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata),
        .rdata_i(rdata));
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rc(input logic [5:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        host.rd(a, d);
        chk(nm, d, e);
    endtask : rc
    task automatic ic(input logic e);
        chk("irq", {7'h00, irq}, {7'h00, e});
    endtask : ic
    // Bits go out LSB first, one tick per cycle
    task automatic send(input int ch, input int n, input logic [7:0] d, input logic ok);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            tick[ch] <= 1'h1;
            bdat[ch] <= d[i];
            bok[ch]  <= ok;
        end
        @(posedge clk);
        tick[ch] <= 1'h0;
        bdat[ch] <= ~bdat[ch];
        repeat (2) @(posedge clk);
        #1;
    endtask : send
    initial begin
        #100000;
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'h0;
        rc(ADDR_RX_STATUS, RST_STATUS, "status reset");
        rc(ADDR_RX_EN, RST_ENABLE, "enable reset");
        rc(ADDR_SERDES_CTL, {4'h0, RST_SERDES_CTL}, "ctl reset");
        host.wr(ADDR_RX_EN, 8'hFF);
        b = 8'($random(seed));
        send(0, 8, b, 1'h1);
        ic(1'h1);
        rc(ADDR_RX_STATUS, 8'h09, "full valid A");
        ic(1'h0);
        rc(ADDR_DATA_A, b, "data A");
        host.rd(ADDR_DATA_A, v);
        rc(ADDR_RX_STATUS, 8'h04, "underflow A");
        send(0, 8, b, 1'h1);
        send(0, 8, ~b, 1'h1);
        rc(ADDR_RX_STATUS, 8'h0D, "overflow A");
        rc(ADDR_DATA_A, ~b, "newest A");
        host.wr(ADDR_RX_EN, 8'h04);
        host.rd(ADDR_DATA_A, v);
        ic(1'h0);
        host.wr(ADDR_RX_EN, 8'h08);
        ic(1'h1);
        rc(ADDR_RX_STATUS, 8'h04, "flow A");
        b = 8'($random(seed));
        host.wr(ADDR_RX_EN, 8'h00);
        send(1, 8, b, 1'h1);
        ic(1'h0);
        host.wr(ADDR_RX_EN, 8'h10);
        ic(1'h1);
        rc(ADDR_RX_STATUS, 8'h90, "full valid B");
        rc(ADDR_DATA_B, b, "data B");
        host.wr(ADDR_RX_EN, 8'h80);
        host.rd(ADDR_DATA_B, v);
        ic(1'h1);
        rc(ADDR_RX_STATUS, 8'h40, "flow B");
        send(0, 3, b, 1'h1);
        // Leaving receive mode drops the open frame on A
        @(posedge clk);
        rx_en <= 1'h0;
        @(posedge clk);
        rx_en <= 1'h1;
        host.wr(ADDR_SERDES_CTL, 8'h00);
        host.wr(ADDR_RX_EN, 8'h02);
        send(0, 3, b, 1'h0);
        rc(ADDR_RX_STATUS, 8'h00, "no eof idle");
        send(0, 3, b, 1'h1);
        send(0, 1, b, 1'h0);
        ic(1'h1);
        rc(ADDR_RX_STATUS, 8'h03, "eof gap 0");
        rc(ADDR_DATA_A, {5'h00, b[2:0]}, "partial A");
        host.wr(ADDR_SERDES_CTL, 8'h03);
        send(0, 1, b, 1'h1);
        send(0, 3, b, 1'h0);
        rc(ADDR_RX_STATUS, 8'h00, "gap held");
        send(0, 1, b, 1'h0);
        rc(ADDR_RX_STATUS, 8'h03, "eof gap 3");
        send(0, 8, b, 1'h1);
        @(posedge clk);
        rx_en <= 1'h0;
        rc(ADDR_RX_STATUS, 8'h00, "rx off");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
